// ---- eew_eeprom_access.sv ----
// Data EEPROM access logic: decodes external data moves into the EEPROM array or the expanded RAM.
// Assumes the CPU core presents one-cycle move strobes and the expanded RAM answers one cycle later.
`timescale 1ns/1ps

// What this block does
// [R1] A 2 Kbyte array sits at 0000h to 07FFh of external data space and is selected only while enabled.
// [R2] The array is read and written by the ordinary external data move, with no other access path.
// [R3] Writes are taken a byte at a time, each stored at the addressed location as for RAM.
// [R4] Software checks the pending flag clear and masks interrupts that touch external data before writing.
// [R5] Software loads the pointer and accumulator, sets the space enable, then issues one move write.
// [R6] Software clears the space enable right after the write and restores interrupts.
// [R7] An accepted write sets the pending flag and the array refuses reads and writes while it stands.
// [R8] Hardware clears the pending flag when the programming cycle completes.
// [R9] With the space enable clear, accesses in the overlaid range go to the expanded RAM.
module eew_eeprom_access #(
	parameter int PROG_CYCLES = eew_pkg::EEW_PROG_CYCLES
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic eepromSpaceEnable,
	input wire eew_pkg::eew_xreq_type xReq,
	output eew_pkg::eew_xrsp_type xRsp,
	output eew_pkg::eew_ram_type ramReq,
	input wire logic [7:0] ramRdata,
	output logic eepromWritePending,
	output logic eepromRefused
);
	import eew_pkg::*;

	typedef enum logic [1:0] {
		EEW_IDLE = 2'b01,
		EEW_PROG = 2'b10
	} eew_state_type;

	// Returned for array reads that arrive while a byte is programming
	localparam logic [7:0] BUSY_READ_DATA = 8'hff;

	// Byte position inside the array for a move address
	function automatic logic [EEW_ARRAY_AW-1:0] eew_array_index(input logic [EEW_ADDR_W-1:0] a);
		return a[EEW_ARRAY_AW-1:0];
	endfunction

	logic [7:0] arrayMem [EEW_ARRAY_BYTES];
	eew_state_type state_ff;
	eew_state_type nxt_state;
	logic [EEW_CNT_W-1:0] progCnt_ff;
	logic [EEW_CNT_W-1:0] nxt_progCnt;
	logic [EEW_ARRAY_AW-1:0] progAddr_ff;
	logic [7:0] progData_ff;
	logic arrayRead_ff;
	logic [7:0] arrayData_ff;
	logic arrayReadDly_ff;
	logic [7:0] arrayDataDly_ff;
	logic ramRead_ff;
	logic hitArray;
	logic hitRam;
	logic arrayWrite;
	logic arrayRead;
	logic arrayBusy;
	logic progStart;
	logic progDone;
	logic nxt_pending;
	logic nxt_refused;

	// Address decode of each move
	assign hitArray = eepromSpaceEnable && eew_in_array(xReq.addr); // [R1]
	assign hitRam = !hitArray; // [R9]
	assign arrayWrite = hitArray && xReq.wr; // [R3]
	assign arrayRead = hitArray && xReq.rd; // [R2]
	assign arrayBusy = (state_ff == EEW_PROG);
	assign progStart = arrayWrite && (state_ff == EEW_IDLE);
	assign progDone = arrayBusy && (progCnt_ff == '0);

	// Programming sequencer: one byte, then a fixed self-timed wait
	always_comb begin
		nxt_state = state_ff;
		nxt_progCnt = progCnt_ff;
		unique case (state_ff)
			EEW_IDLE: begin
				if (arrayWrite) begin // [R3]
					nxt_state = EEW_PROG; // [R7]
					nxt_progCnt = EEW_CNT_W'(PROG_CYCLES - 1);
				end
			end
			EEW_PROG: begin
				if (progCnt_ff == '0) begin
					nxt_state = EEW_IDLE; // [R8]
				end else begin
					nxt_progCnt = progCnt_ff - EEW_CNT_W'(1);
				end
			end
			default: begin
				nxt_state = EEW_IDLE;
				nxt_progCnt = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state_ff <= EEW_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			progCnt_ff <= '0;
		end else begin
			progCnt_ff <= nxt_progCnt;
		end
	end

	// Byte and location held for the whole programming time
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			progAddr_ff <= '0;
			progData_ff <= EEW_DATA_RESET;
		end else if (progStart) begin
			progAddr_ff <= eew_array_index(xReq.addr); // [R3]
			progData_ff <= xReq.wdata;
		end
	end

	// Array store commits at the end of programming
	always_ff @(posedge clk_sys) begin
		if (progDone) begin
			arrayMem[progAddr_ff] <= progData_ff; // [R3] [R8]
		end
	end

	// Array read through the move path, refused while programming
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			arrayRead_ff <= 1'b0;
			arrayData_ff <= EEW_DATA_RESET;
		end else begin
			arrayRead_ff <= arrayRead; // [R2]
			if (arrayRead) begin
				if (arrayBusy) begin
					arrayData_ff <= BUSY_READ_DATA; // [R7]
				end else begin
					arrayData_ff <= arrayMem[eew_array_index(xReq.addr)];
				end
			end
		end
	end

	// Extra stage so array answers land on the same edge as expanded RAM answers
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			arrayReadDly_ff <= 1'b0;
			arrayDataDly_ff <= EEW_DATA_RESET;
		end else begin
			arrayReadDly_ff <= arrayRead_ff;
			arrayDataDly_ff <= arrayData_ff;
		end
	end

	// Forwarding to the expanded RAM
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ramReq <= '0;
		end else begin
			ramReq.rd <= hitRam && xReq.rd; // [R9]
			ramReq.wr <= hitRam && xReq.wr; // [R9]
			ramReq.addr <= xReq.addr;
			ramReq.wdata <= xReq.wdata;
		end
	end

	// RAM data is valid one cycle after the forwarded read
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ramRead_ff <= 1'b0;
		end else begin
			ramRead_ff <= ramReq.rd;
		end
	end

	// Equal latency on both paths keeps back-to-back mixed reads from colliding
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			xRsp <= '0;
		end else begin
			xRsp.ack <= arrayReadDly_ff || ramRead_ff; // [R2]
			if (arrayReadDly_ff) begin
				xRsp.rdata <= arrayDataDly_ff;
			end else if (ramRead_ff) begin
				xRsp.rdata <= ramRdata; // [R9]
			end else begin
				xRsp.rdata <= EEW_DATA_RESET;
			end
		end
	end

	// Busy flag rises with the accepted byte and drops with the commit
	always_comb begin
		nxt_pending = progStart || (arrayBusy && !progDone); // [R7] [R8]
		nxt_refused = arrayBusy && (arrayRead || arrayWrite); // [R7]
	end

	// Busy flag register
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			eepromWritePending <= EEW_PENDING_RESET;
		end else begin
			eepromWritePending <= nxt_pending; // [R7] [R8]
		end
	end

	// Access that reached the array while it was programming
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			eepromRefused <= 1'b0;
		end else begin
			eepromRefused <= nxt_refused; // [R7]
		end
	end

endmodule

// ---- eew_eeprom_access_asserts.sv ----
// Checker for the EEPROM access block ports.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/1ps
module eew_eeprom_access_asserts import eew_pkg::*; #(parameter int PROG_CYCLES = EEW_PROG_CYCLES) (
	input wire logic clk_sys, input wire logic nrst, input wire logic eepromSpaceEnable,
	input wire eew_xreq_type xReq, input wire eew_xrsp_type xRsp, input wire eew_ram_type ramReq,
	input wire logic eepromWritePending, input wire logic eepromRefused
);
	logic [15:0] busyCnt;
	wire arr = eepromSpaceEnable && (xReq.addr <= EEW_ARRAY_LAST);
	always_ff @(posedge clk_sys) busyCnt <= (!nrst || !eepromWritePending) ? '0 : busyCnt + 16'h1;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence s_ans; ##3 xRsp.ack; endsequence
	sequence s_busy_ans; eepromRefused ##2 (xRsp.ack && xRsp.rdata == 8'hff); endsequence
	a_write_busy: assert property (xReq.wr && arr && !eepromWritePending |=> eepromWritePending && !ramReq.wr)
		else $error("array write did not start programming");
	a_read_ack: assert property (xReq.rd |-> s_ans)
		else $error("read answer missing");
	a_busy_read: assert property (xReq.rd && arr && eepromWritePending |=> s_busy_ans)
		else $error("busy read not refused");
	a_busy_len: assert property ($fell(eepromWritePending) |-> busyCnt == PROG_CYCLES)
		else $error("programming length wrong");
	a_ram_route: assert property (xReq.wr && !eepromSpaceEnable |=> ramReq.wr && ramReq.addr == $past(xReq.addr))
		else $error("write not sent to expanded RAM");
	a_array_map: assert property ((xReq.wr || xReq.rd) && arr |=> !ramReq.wr && !ramReq.rd)
		else $error("array access leaked to RAM");
	a_busy_write: assert property (xReq.wr && arr && eepromWritePending |=> eepromRefused && !ramReq.wr)
		else $error("busy write not refused");
	a_ack_cause: assert property (xRsp.ack |-> $past(xReq.rd, 3))
		else $error("answer without a read");
endmodule
bind eew_eeprom_access eew_eeprom_access_asserts #(.PROG_CYCLES(PROG_CYCLES)) i_chk (.clk_sys(clk_sys),
	.nrst(nrst), .eepromSpaceEnable(eepromSpaceEnable), .xReq(xReq), .xRsp(xRsp), .ramReq(ramReq),
	.eepromWritePending(eepromWritePending), .eepromRefused(eepromRefused));

// ---- eew_eeprom_access_tb.sv ----
// Testbench for the EEPROM access block with an expanded RAM model.
// Assumes short programming time set by parameter.
`timescale 1ns/1ps
module eew_eeprom_access_tb;
	import eew_pkg::*;
	logic clk_sys = 0, nrst = 0, en = 0, pending, refused;
	eew_xreq_type xReq = '0;
	eew_xrsp_type xRsp;
	eew_ram_type ramReq;
	logic [7:0] ramRdata;
	int mismatches = 0, total_checks = 0, cyc = 0;
	always #4 clk_sys = ~clk_sys;
	eew_eeprom_access #(.PROG_CYCLES(8)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .eepromSpaceEnable(en),
		.xReq(xReq), .xRsp(xRsp), .ramReq(ramReq), .ramRdata(ramRdata), .eepromWritePending(pending),
		.eepromRefused(refused));
	eew_expanded_data_ram_model i_ram (.clk_sys(clk_sys), .ramReq(ramReq), .ramRdata(ramRdata));
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task mv(input logic r, input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys) xReq = '{r, w, a, d};
		@(negedge clk_sys) xReq = '0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		mv(1'b1, 1'b0, a, 8'h00);
		repeat (2) @(negedge clk_sys);
		chk("ack", 8'h01, {7'h0, xRsp.ack});
		chk("rdata", e, xRsp.rdata);
	endtask
	task test_ram;
		mv(1'b0, 1'b1, 16'h0005, 8'ha5);
		@(negedge clk_sys) chk("pending", 8'h00, {7'h0, pending});
		mv(1'b0, 1'b1, 16'h07ff, 8'h3c);
		rd(16'h0005, 8'ha5);
		en = 1;
		mv(1'b0, 1'b1, 16'h0800, 8'hc3);
		rd(16'h0800, 8'hc3);
		en = 0;
		$display("test_ram done");
	endtask
	task test_array;
		chk("idle", 8'h00, {7'h0, pending});
		en = 1;
		mv(1'b0, 1'b1, 16'h07ff, 8'h5a);
		en = 0;
		@(negedge clk_sys) chk("pending", 8'h01, {7'h0, pending});
		en = 1;
		mv(1'b1, 1'b0, 16'h07ff, 8'h00);
		chk("refused", 8'h01, {7'h0, refused});
		repeat (2) @(negedge clk_sys);
		chk("busy ack", 8'h01, {7'h0, xRsp.ack});
		chk("busy rdata", 8'hff, xRsp.rdata);
		mv(1'b0, 1'b1, 16'h07ff, 8'h11);
		chk("refused", 8'h01, {7'h0, refused});
		chk("pending", 8'h01, {7'h0, pending});
		@(negedge clk_sys) chk("done", 8'h00, {7'h0, pending});
		rd(16'h07ff, 8'h5a);
		en = 0;
		rd(16'h07ff, 8'h3c);
		$display("test_array done");
	endtask
	task test_reset;
		en = 1;
		mv(1'b0, 1'b1, 16'h0010, 8'h77);
		nrst = 0;
		repeat (2) @(negedge clk_sys);
		chk("reset pending", 8'h00, {7'h0, pending});
		nrst = 1;
		en = 0;
		rd(16'h0005, 8'ha5);
		$display("test_reset done");
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 500) begin
			mismatches++;
			end_sim;
		end
	end
	initial begin
		repeat (4) @(negedge clk_sys);
		nrst = 1;
		test_ram;
		test_array;
		test_reset;
		end_sim;
	end
endmodule

// ---- eew_expanded_data_ram_model.sv ----
// Expanded data RAM model behind the EEPROM access block.
// Assumes registered requests; read data is valid the cycle after a read.
`timescale 1ns/1ps
module eew_expanded_data_ram_model import eew_pkg::*; (
	input wire logic clk_sys,
	input wire eew_ram_type ramReq,
	output logic [7:0] ramRdata
);
	logic [7:0] mem [logic [15:0]];
	initial ramRdata = 8'h00;
	// Idle data toggles so stale bytes never look valid
	always @(posedge clk_sys) begin
		if (ramReq.wr) mem[ramReq.addr] = ramReq.wdata;
		ramRdata <= ramReq.rd ? mem[ramReq.addr] : ~ramRdata;
	end
endmodule

// ---- eew_pkg.sv ----
// Package for the data EEPROM write access block: address map, timing and bus carriers.
// Assumes one clock at 125 MHz shared with the CPU core.
package eew_pkg;

	localparam int EEW_ADDR_W = 16;
	localparam int EEW_DATA_W = 8;
	localparam logic [15:0] EEW_ARRAY_BASE = 16'h0000;
	localparam logic [15:0] EEW_ARRAY_LAST = 16'h07ff;
	localparam int EEW_ARRAY_BYTES = 2048;
	localparam int EEW_ARRAY_AW = 11;

	// Programming time of one byte, in microseconds, and its cycle count
	localparam int EEW_CLK_MHZ = 125;
	localparam int EEW_PROG_TIME_US = 10;
	localparam int EEW_PROG_CYCLES = EEW_PROG_TIME_US * EEW_CLK_MHZ;
	localparam int EEW_CNT_W = 16;

	localparam logic EEW_ENABLE_RESET = 1'b0;
	localparam logic EEW_PENDING_RESET = 1'b0;
	localparam logic [7:0] EEW_DATA_RESET = 8'h00;

	// One external data move from the CPU core
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} eew_xreq_type;

	// Answer to the CPU core
	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
	} eew_xrsp_type;

	// Access forwarded to the expanded data RAM
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} eew_ram_type;

	function automatic logic eew_in_array(input logic [15:0] a);
		return (a >= EEW_ARRAY_BASE) && (a <= EEW_ARRAY_LAST);
	endfunction

endpackage
